// ===== aics_pkg.sv
// =============================================================================
// Shared constants for the converter input channel select block.
package aics_pkg;

  // =============================================================================
  // Register byte offsets.
  localparam logic [7:0] AICS_OFS_CH123   = 8'h00;
  localparam logic [7:0] AICS_OFS_CH0     = 8'h04;
  localparam logic [7:0] AICS_OFS_SCAN    = 8'h08;
  localparam logic [7:0] AICS_OFS_PORT    = 8'h0C;
  localparam logic [7:0] AICS_OFS_CTRL    = 8'h10;
  localparam logic [7:0] AICS_OFS_STATUS  = 8'h14;

  // =============================================================================
  // Writable bit masks; every other bit reads as zero.
  localparam logic [15:0] AICS_MASK_CH123 = 16'h0707;
  localparam logic [15:0] AICS_MASK_CH0   = 16'h9F9F;
  localparam logic [15:0] AICS_MASK_SCAN  = 16'h03FF;
  localparam logic [15:0] AICS_MASK_PORT  = 16'h03FF;
  localparam logic [15:0] AICS_MASK_CTRL  = 16'h000F;
  localparam logic [15:0] AICS_RST_REG    = 16'h0000;

  // =============================================================================
  // Field positions.
  localparam int AICS_B123_POS_A  = 0;
  localparam int AICS_B123_NEG_A  = 1;
  localparam int AICS_B123_POS_B  = 8;
  localparam int AICS_B123_NEG_B  = 9;
  localparam int AICS_B0_POS_A    = 0;
  localparam int AICS_B0_NEG_A    = 7;
  localparam int AICS_B0_POS_B    = 8;
  localparam int AICS_B0_NEG_B    = 15;
  localparam int AICS_BC_ALT_MODE = 0;
  localparam int AICS_BC_SCAN_EN  = 1;
  localparam int AICS_BC_TWELVE   = 2;
  localparam int AICS_BC_DISABLE  = 3;
  localparam int AICS_BS_PHASE_B  = 0;
  localparam int AICS_BS_SCAN_IDX = 4;
  localparam int AICS_BS_RESERVED = 8;

  // =============================================================================
  // Analog inputs and multiplexer source codes; codes 0 to 9 mean that input.
  localparam int          AICS_NUM_AN      = 10;
  localparam logic [9:0]  AICS_PINS_LARGE  = 10'h3FF;
  localparam logic [9:0]  AICS_PINS_SMALL  = 10'h0CF;
  localparam logic [3:0]  AICS_AN_LAST     = 4'h9;
  localparam logic [3:0]  AICS_SRC_VREF_N  = 4'hA;
  localparam logic [3:0]  AICS_SRC_NC      = 4'hB;
  localparam logic [3:0]  AICS_SRC_LOW_REF = 4'hC;
  localparam logic [3:0]  AICS_SRC_AGND    = 4'hD;

  // =============================================================================
  // Channel 1-3 negative select codes.
  localparam logic [1:0]  AICS_NEG_REF0    = 2'h0;
  localparam logic [1:0]  AICS_NEG_REF1    = 2'h1;
  localparam logic [1:0]  AICS_NEG_AN678   = 2'h2;
  localparam logic [1:0]  AICS_NEG_AN9     = 2'h3;

endpackage

// ===== aics_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R1: In 10-bit mode, channel 1-3 negative code 00 or 01 selects negative reference.
// R2: Large package, code 10 gives inputs 6/7/8; code 11 gives input 9, rest open.
// R3: Small package, code 10 gives inputs 6 and 7, channel 3 open; code 11 reserved.
// R4: Positive select 0 gives inputs 0/1/2; in 12-bit mode channel 1-3 codes reserved.
// R5: Large package, positive select 1 gives inputs 3/4/5.
// R6: Small package, positive select 1 gives input 3, channels 2 and 3 open.
// R7: Channel 1-3 register holds positive selects at bits 8 and 0, negatives 10-9, 2-1.
// R8: Channel 0 negative bit (15 B, 7 A) selects input 1 or negative reference.
// R9: Channel 0 five-bit positive code n selects input n; large package accepts 0 to 9.
// R10: Small package treats codes 4 and 5 as reserved; 0-3, 6, 7 are inputs.
// R11: Scan mask bit n includes input n in the scan when set.
// R12: All mask bits writable; scanning an input without pin converts low reference.
// R13: Port bit set makes pin digital, read input on, multiplexer sees analog ground.
// R14: Port bit clear makes pin analog, read input off, pin voltage sampled.
// R15: All ten port bits read and write; bits without an input have no effect.
// R16: With the module disabled, port bits do nothing and analog pins are digital.
// R17: Unimplemented bits read as zero.
// R18: Implemented bits reset to zero and read back the last written value.
// R19: Alternate mode uses sample A selects, then sample B; otherwise always A.
// R20: Channel 0 scan enable walks the scan mask during sample A.
// R21: Sample B channel 1-3 negative select lives at bits 10-9.
module aics_top
  import aics_pkg::*;
#(
  parameter bit LARGE_PACKAGE = 1'b1
) (
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        sample_done,
  output logic [3:0]       ch0_pos_src,
  output logic [3:0]       ch0_neg_src,
  output logic [3:0]       ch1_pos_src,
  output logic [3:0]       ch1_neg_src,
  output logic [3:0]       ch2_pos_src,
  output logic [3:0]       ch2_neg_src,
  output logic [3:0]       ch3_pos_src,
  output logic [3:0]       ch3_neg_src,
  output logic [9:0]       pin_digital_mode,
  output logic             sel_reserved
);

  // =============================================================================
  // Register state.
  logic [15:0] ch123_input_select_q;
  logic [15:0] ch0_input_select_q;
  logic [15:0] scan_input_mask_q;
  logic [15:0] analog_port_config_q;
  logic [15:0] ctrl_q;
  logic        phase_b_q;
  logic [3:0]  scan_idx_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;

  localparam logic [9:0] PINS = LARGE_PACKAGE ? AICS_PINS_LARGE : AICS_PINS_SMALL;

  // =============================================================================
  // Bus decode. One wait state: the answer is prepared in the first access cycle.
  wire         acc_first  = psel & penable & ~pready_q;
  wire         acc_done   = psel & penable & pready_q;
  wire         hit_ch123  = (paddr == AICS_OFS_CH123);
  wire         hit_ch0    = (paddr == AICS_OFS_CH0);
  wire         hit_scan   = (paddr == AICS_OFS_SCAN);
  wire         hit_port   = (paddr == AICS_OFS_PORT);
  wire         hit_ctrl   = (paddr == AICS_OFS_CTRL);
  wire         hit_status = (paddr == AICS_OFS_STATUS);
  wire         hit_any    = hit_ch123 | hit_ch0 | hit_scan | hit_port | hit_ctrl | hit_status;
  wire [15:0]  lane_mask  = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  wire         wr_ok      = acc_done & pwrite;
  wire [15:0]  status_w   = {7'h00, sel_reserved, scan_idx_q, 3'h0, phase_b_q};
  wire [15:0]  rd_mux     = hit_ch123  ? ch123_input_select_q :
                            hit_ch0    ? ch0_input_select_q   :
                            hit_scan   ? scan_input_mask_q    :
                            hit_port   ? analog_port_config_q :
                            hit_ctrl   ? ctrl_q               :
                            hit_status ? status_w             : 16'h0000;

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wmask);
    merge = (old & ~wmask) | (pwdata[15:0] & wmask);
  endfunction

  // Writable masks keep unimplemented bits at zero. R7 R17 R21
  wire [15:0] ch123_d = merge(ch123_input_select_q, AICS_MASK_CH123 & lane_mask);
  wire [15:0] ch0_d   = merge(ch0_input_select_q, AICS_MASK_CH0 & lane_mask);
  wire [15:0] scan_d  = merge(scan_input_mask_q, AICS_MASK_SCAN & lane_mask);
  wire [15:0] port_d  = merge(analog_port_config_q, AICS_MASK_PORT & lane_mask);
  wire [15:0] ctrl_d  = merge(ctrl_q, AICS_MASK_CTRL & lane_mask);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch123_input_select_q <= AICS_RST_REG; // R18
      ch0_input_select_q   <= AICS_RST_REG;
      scan_input_mask_q    <= AICS_RST_REG;
      analog_port_config_q <= AICS_RST_REG;
      ctrl_q               <= AICS_RST_REG;
    end else if (wr_ok) begin
      if (hit_ch123) ch123_input_select_q <= ch123_d; // R18
      if (hit_ch0)   ch0_input_select_q   <= ch0_d;
      if (hit_scan)  scan_input_mask_q    <= scan_d;  // R12
      if (hit_port)  analog_port_config_q <= port_d;  // R15
      if (hit_ctrl)  ctrl_q               <= ctrl_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first & ~hit_any;
      prdata_q  <= (acc_first & ~pwrite) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;

  // =============================================================================
  // Sample phase and scan pointer.
  wire alt_mode  = ctrl_q[AICS_BC_ALT_MODE];
  wire scan_en   = ctrl_q[AICS_BC_SCAN_EN];
  wire twelve    = ctrl_q[AICS_BC_TWELVE];
  wire mod_off   = ctrl_q[AICS_BC_DISABLE];
  wire use_b     = alt_mode & phase_b_q; // R19
  wire scanning  = scan_en & ~use_b; // R20

  function automatic logic [3:0] next_scan(input logic [3:0] cur, input logic [9:0] msk);
    logic [3:0] idx;
    next_scan = cur;
    idx = cur;
    for (int k = 0; k < AICS_NUM_AN; k++) begin
      idx = (idx == AICS_AN_LAST) ? 4'h0 : 4'(idx + 4'h1);
      if (msk[idx] && next_scan == cur && k < AICS_NUM_AN - 1) next_scan = idx;
    end
    if (next_scan == cur && !msk[cur]) begin
      for (int j = AICS_NUM_AN - 1; j >= 0; j--) begin
        if (msk[j]) next_scan = 4'(j);
      end
    end
  endfunction

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      phase_b_q  <= 1'b0;
      scan_idx_q <= 4'h0;
    end else begin
      if (!alt_mode) begin
        phase_b_q <= 1'b0; // R19
      end else if (sample_done) begin
        phase_b_q <= ~phase_b_q; // R19
      end
      if (sample_done && scanning) begin
        scan_idx_q <= next_scan(scan_idx_q, scan_input_mask_q[9:0]); // R11 R20
      end
    end
  end

  // =============================================================================
  // Routing. A source that is a pin set digital by its port bit sees analog ground while the module is on.
  function automatic logic [3:0] gate_pin(input logic [3:0] src, input logic [9:0] dig);
    gate_pin = src;
    if (src <= AICS_AN_LAST && dig[src]) gate_pin = AICS_SRC_AGND; // R13 R14
  endfunction

  wire        pos123   = use_b ? ch123_input_select_q[AICS_B123_POS_B]
                               : ch123_input_select_q[AICS_B123_POS_A];
  wire [1:0]  neg123   = use_b ? ch123_input_select_q[AICS_B123_NEG_B +: 2]
                               : ch123_input_select_q[AICS_B123_NEG_A +: 2]; // R7 R21
  wire        neg0     = use_b ? ch0_input_select_q[AICS_B0_NEG_B]
                               : ch0_input_select_q[AICS_B0_NEG_A];
  wire [4:0]  pos0_fix = use_b ? ch0_input_select_q[AICS_B0_POS_B +: 5]
                               : ch0_input_select_q[AICS_B0_POS_A +: 5];
  wire        fix_ok   = (pos0_fix <= 5'(AICS_AN_LAST)) && PINS[pos0_fix[3:0]]; // R9 R10
  wire        neg_rsv  = ~LARGE_PACKAGE & (neg123 == AICS_NEG_AN9); // R3

  // Port bits only act on inputs that exist and while the module is on. R15 R16
  wire [9:0]  eff_dig  = mod_off ? 10'h000 : (analog_port_config_q[9:0] & PINS);

  logic [3:0] p1, p2, p3, n1, n2, n3, p0;
  logic       rsv_d;
  logic [9:0] pin_dig_d;

  always_comb begin
    p1 = AICS_SRC_NC;
    p2 = AICS_SRC_NC;
    p3 = AICS_SRC_NC;
    n1 = AICS_SRC_NC;
    n2 = AICS_SRC_NC;
    n3 = AICS_SRC_NC;
    rsv_d = 1'b0;
    if (!twelve) begin // R4
      if (!pos123) begin
        p1 = 4'h0; // R4
        p2 = 4'h1;
        p3 = 4'h2;
      end else begin
        p1 = 4'h3; // R5 R6
        p2 = LARGE_PACKAGE ? 4'h4 : AICS_SRC_NC;
        p3 = LARGE_PACKAGE ? 4'h5 : AICS_SRC_NC;
      end
      case (neg123)
        AICS_NEG_REF0, AICS_NEG_REF1: begin
          n1 = AICS_SRC_VREF_N; // R1
          n2 = AICS_SRC_VREF_N;
          n3 = AICS_SRC_VREF_N;
        end
        AICS_NEG_AN678: begin
          n1 = 4'h6; // R2 R3
          n2 = 4'h7;
          n3 = LARGE_PACKAGE ? 4'h8 : AICS_SRC_NC;
        end
        default: begin
          n1 = LARGE_PACKAGE ? 4'h9 : AICS_SRC_NC; // R2 R3
          rsv_d = neg_rsv;
        end
      endcase
    end
    if (scanning) begin
      p0 = PINS[scan_idx_q] ? scan_idx_q : AICS_SRC_LOW_REF; // R12 R20
    end else if (fix_ok) begin
      p0 = pos0_fix[3:0]; // R9 R10
    end else begin
      p0 = AICS_SRC_NC;
      rsv_d = 1'b1;
    end
  end

  for (genvar i = 0; i < AICS_NUM_AN; i++) begin : g_pin
    assign pin_dig_d[i] = PINS[i] & (mod_off | analog_port_config_q[i]); // R13 R16
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ch0_pos_src      <= 4'h0;
      ch0_neg_src      <= AICS_SRC_VREF_N;
      ch1_pos_src      <= 4'h0;
      ch1_neg_src      <= AICS_SRC_VREF_N;
      ch2_pos_src      <= 4'h1;
      ch2_neg_src      <= AICS_SRC_VREF_N;
      ch3_pos_src      <= 4'h2;
      ch3_neg_src      <= AICS_SRC_VREF_N;
      pin_digital_mode <= 10'h000;
      sel_reserved     <= 1'b0;
    end else begin
      ch0_pos_src      <= gate_pin(p0, eff_dig);
      ch0_neg_src      <= neg0 ? gate_pin(4'h1, eff_dig) : AICS_SRC_VREF_N; // R8
      ch1_pos_src      <= gate_pin(p1, eff_dig);
      ch1_neg_src      <= gate_pin(n1, eff_dig);
      ch2_pos_src      <= gate_pin(p2, eff_dig);
      ch2_neg_src      <= gate_pin(n2, eff_dig);
      ch3_pos_src      <= gate_pin(p3, eff_dig);
      ch3_neg_src      <= gate_pin(n3, eff_dig);
      pin_digital_mode <= pin_dig_d;
      sel_reserved     <= rsv_d;
    end
  end

  // =============================================================================
  // Checks.
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_ten_bit_a;
    !twelve && !use_b && !mod_off;
  endsequence

  sequence s_read_ch123;
    acc_first && !pwrite && hit_ch123;
  endsequence

  sequence s_alt_step;
    alt_mode && !phase_b_q && sample_done ##1 alt_mode;
  endsequence

  sequence s_read_ch0;
    acc_first && !pwrite && hit_ch0;
  endsequence

  sequence s_alt_back;
    alt_mode && phase_b_q && sample_done;
  endsequence

  AST_NEG_VREF: assert property (s_ten_bit_a and (neg123[1] == 1'b0) |=> // R1
    ch1_neg_src == AICS_SRC_VREF_N && ch3_neg_src == AICS_SRC_VREF_N)
    else $error("negative select 0x did not give the negative reference");
  AST_NEG_AN8: assert property (s_ten_bit_a and LARGE_PACKAGE // R2
    and (neg123 == AICS_NEG_AN678) and !analog_port_config_q[8] |=> ch3_neg_src == 4'h8)
    else $error("negative select 10 did not route channel 3 to input 8");
  AST_POS_HIGH: assert property (s_ten_bit_a and pos123 and !analog_port_config_q[4] // R5 R6
    |=> ch2_pos_src == (LARGE_PACKAGE ? 4'h4 : AICS_SRC_NC))
    else $error("positive select 1 routed channel 2 wrongly");
  AST_CH0_FIXED: assert property (!scanning && fix_ok && eff_dig == 10'h000 // R9
    |=> ch0_pos_src == $past(pos0_fix[3:0]))
    else $error("channel 0 positive select did not follow its code");
  AST_SCAN_HIT: assert property (sample_done && scanning && scan_input_mask_q[9:0] != 10'h000 // R11
    |=> scan_input_mask_q[scan_idx_q])
    else $error("scan pointer landed on a skipped input");
  AST_DIG_GROUND: assert property (analog_port_config_q[3] && !mod_off && p0 == 4'h3 // R13
    |=> pin_digital_mode[3] && ch0_pos_src == AICS_SRC_AGND)
    else $error("digital pin was not grounded at the multiplexer");
  AST_OFF_DIGITAL: assert property (mod_off [*2] |-> pin_digital_mode == PINS) // R16
    else $error("disabled module left an analog pin out of digital mode");
  AST_READ_ZERO: assert property (s_read_ch123 |=> pready && prdata[7:3] == 5'h00 // R17
    && prdata[31:11] == 21'h000000)
    else $error("unimplemented bits read as one");
  AST_ALT_PHASE: assert property (s_alt_step |-> phase_b_q ##0 use_b) // R19
    else $error("alternate mode did not move to sample B");
  AST_WRITE_BACK: assert property (wr_ok && hit_ch0 && pstrb == 4'hF // R18
    |=> ch0_input_select_q == ($past(pwdata[15:0]) & AICS_MASK_CH0))
    else $error("channel 0 select did not hold the written value");

  // =============================================================================
  // Further route checks. Each route is registered, so it is checked on the edge after its
  // cause; a later look could let a route that is one cycle stale slip through.
  AST_NEG_AN9: assert property (s_ten_bit_a and LARGE_PACKAGE // R2
    and (neg123 == AICS_NEG_AN9) and !analog_port_config_q[9] |=> ch1_neg_src == 4'h9
    && ch2_neg_src == AICS_SRC_NC)
    else $error("negative select 11 did not route channel 1 to input 9");
  AST_NEG_RSV: assert property (!LARGE_PACKAGE && !twelve && neg123 == AICS_NEG_AN9 // R3
    |=> sel_reserved)
    else $error("reserved negative select was not flagged");
  AST_POS_LOW: assert property (s_ten_bit_a and !pos123 and eff_dig[2:0] == 3'h0 // R4
    |=> ch1_pos_src == 4'h0 && ch2_pos_src == 4'h1 && ch3_pos_src == 4'h2)
    else $error("positive select 0 routed channels 1-3 wrongly");
  AST_TWELVE_NC: assert property (twelve |=> ch1_pos_src == AICS_SRC_NC // R4
    && ch2_neg_src == AICS_SRC_NC && ch3_pos_src == AICS_SRC_NC && ch3_neg_src == AICS_SRC_NC)
    else $error("12-bit mode left a channel 1-3 input connected");
  AST_POS_SMALL: assert property (!LARGE_PACKAGE && !twelve && pos123 // R6
    |=> ch2_pos_src == AICS_SRC_NC && ch3_pos_src == AICS_SRC_NC)
    else $error("positive select 1 connected a missing input");
  AST_CH0_NEG: assert property (!eff_dig[1] // R8
    |=> ch0_neg_src == ($past(neg0) ? 4'h1 : AICS_SRC_VREF_N))
    else $error("channel 0 negative select did not follow its bit");
  AST_CH0_RSV: assert property (!scanning && !fix_ok // R10
    |=> sel_reserved && ch0_pos_src == AICS_SRC_NC)
    else $error("reserved channel 0 code was not flagged");
  AST_SCAN_ABSENT: assert property (scanning && !PINS[scan_idx_q] // R12
    |=> ch0_pos_src == AICS_SRC_LOW_REF)
    else $error("scan of a missing input did not give the low reference");
  AST_ANALOG_PIN: assert property (!mod_off && !analog_port_config_q[3] // R14
    && p0 == 4'h3
    |=> !pin_digital_mode[3] && ch0_pos_src == 4'h3)
    else $error("analog pin was not passed to the multiplexer");
  AST_OFF_NO_GROUND: assert property (mod_off && p0 == 4'h3 // R16
    |=> ch0_pos_src == 4'h3)
    else $error("port bit grounded an input while the module was off");
  AST_READ_CH0_ZERO: assert property (s_read_ch0 |=> pready // R17
    && prdata[14:13] == 2'h0 && prdata[6:5] == 2'h0)
    else $error("unimplemented channel 0 bits read as one");
  AST_ALT_BACK: assert property (s_alt_back |=> !phase_b_q) // R19
    else $error("alternate mode did not return to sample A");
  AST_ALT_OFF: assert property (!alt_mode |=> !phase_b_q) // R19
    else $error("sample B was used with alternate mode clear");
  AST_NEG_B: assert property (alt_mode && phase_b_q && !twelve && !mod_off // R21
    && ch123_input_select_q[AICS_B123_NEG_B +: 2] == AICS_NEG_AN678 && eff_dig[7:6] == 2'h0
    |=> ch1_neg_src == 4'h6 && ch2_neg_src == 4'h7)
    else $error("sample B negative select was not used");
  AST_SCAN_HOLD: assert property (!(sample_done && scanning) |=> $stable(scan_idx_q)) // R20
    else $error("scan pointer moved without a scanned sample");

endmodule

// ===== aics_seq_model.sv
`timescale 1ns/1ps
// =============================================================================
// Sequencer stand-in: one sample-finished pulse for each start request.
module aics_seq_model (
  input  wire logic sys_clk,
  input  wire logic sys_rst,
  input  wire logic start,
  input  wire logic slow,
  output logic      sample_done
);
  logic [2:0] wait_q;

  // A slow sample makes the block hold its route across several idle cycles.
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wait_q      <= 3'h0;
      sample_done <= 1'b0;
    end else begin
      sample_done <= (wait_q == 3'h1);
      if (start) begin
        wait_q <= slow ? 3'h6 : 3'h1;
      end else if (wait_q != 3'h0) begin
        wait_q <= wait_q - 3'h1;
      end
    end
  end
endmodule

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import aics_pkg::*;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        start = 1'b0;
  logic        slow = 1'b0;
  logic        pready, pslverr, sample_done, sel_l, sel_s;
  logic [31:0] prdata;
  logic [3:0]  sl [8];
  logic [3:0]  ss [8];
  logic [9:0]  pdm_l, pdm_s;
  logic [23:0] r123_l, r123_s;
  int          err_total = 0;
  int          tests_run = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        er;
  logic [3:0]  scan_l [3] = '{4'h4, 4'h9, 4'h0};
  logic [3:0]  scan_s [3] = '{AICS_SRC_LOW_REF, AICS_SRC_LOW_REF, 4'h0};
  logic [7:0]  ofs [4] = '{AICS_OFS_CH123, AICS_OFS_CH0, AICS_OFS_SCAN, AICS_OFS_PORT};
  logic [15:0] msk [4] = '{16'h0707, 16'h9F9F, 16'h03FF, 16'h03FF};

  always #25 sys_clk = ~sys_clk;
  assign r123_l = {sl[2], sl[3], sl[4], sl[5], sl[6], sl[7]};
  assign r123_s = {ss[2], ss[3], ss[4], ss[5], ss[6], ss[7]};

  aics_top #(.LARGE_PACKAGE(1'b1)) dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .sample_done(sample_done),
    .ch0_pos_src(sl[0]), .ch0_neg_src(sl[1]), .ch1_pos_src(sl[2]), .ch1_neg_src(sl[3]),
    .ch2_pos_src(sl[4]), .ch2_neg_src(sl[5]), .ch3_pos_src(sl[6]), .ch3_neg_src(sl[7]),
    .pin_digital_mode(pdm_l), .sel_reserved(sel_l));
  // The small-package copy shares the bus; only its routes and its reserved flag are observed.
  aics_top #(.LARGE_PACKAGE(1'b0)) dut_small (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .pready(), .prdata(), .pslverr(), .sample_done(sample_done),
    .ch0_pos_src(ss[0]), .ch0_neg_src(ss[1]), .ch1_pos_src(ss[2]), .ch1_neg_src(ss[3]),
    .ch2_pos_src(ss[4]), .ch2_neg_src(ss[5]), .ch3_pos_src(ss[6]), .ch3_neg_src(ss[7]),
    .pin_digital_mode(pdm_s), .sel_reserved(sel_s));
  aics_seq_model seq (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start), .slow(slow),
    .sample_done(sample_done));

  // =============================================================================
  // Access and comparison tasks.
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic settle();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    apb(1'b1, a, {16'h0, d});
    settle();
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input logic exp_er);
    apb(1'b0, a, 32'h0);
    chk(rd, {16'h0, exp});
    chk(er, exp_er);
  endtask

  task automatic pulse(input logic s);
    @(posedge sys_clk);
    start <= 1'b1;
    slow  <= s;
    @(posedge sys_clk);
    start <= 1'b0;
    do begin
      @(posedge sys_clk);
    end while (sample_done !== 1'b1);
    settle();
  endtask

  function automatic logic [23:0] exp123(input logic p, input logic [1:0] n, input logic big);
    logic [3:0] q [6];
    q = '{p ? 4'h3 : 4'h0, AICS_SRC_VREF_N, p ? (big ? 4'h4 : AICS_SRC_NC) : 4'h1,
      AICS_SRC_VREF_N, p ? (big ? 4'h5 : AICS_SRC_NC) : 4'h2, AICS_SRC_VREF_N};
    if (n == 2'h2) begin
      q[1] = 4'h6;
      q[3] = 4'h7;
      q[5] = big ? 4'h8 : AICS_SRC_NC;
    end else if (n == 2'h3) begin
      q[1] = 4'h9;
      q[3] = AICS_SRC_NC;
      q[5] = AICS_SRC_NC;
    end
    return {q[0], q[1], q[2], q[3], q[4], q[5]};
  endfunction

  // A hung handshake is cut short here.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      conclude();
    end
  end

  // =============================================================================
  // Scenarios.
  initial begin
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    settle();
    chk(r123_l, exp123(1'b0, 2'h0, 1'b1));
    for (int i = 0; i < 4; i++) begin
      rd_chk(ofs[i], 16'h0000, 1'b0);
      wr(ofs[i], 16'hFFFF);
      rd_chk(ofs[i], msk[i], 1'b0);
    end
    chk(pdm_l, 10'h3FF);
    for (int i = 0; i < 4; i++) begin
      wr(ofs[i], 16'h0000);
    end
    rd_chk(8'h20, 16'h0000, 1'b1);
    for (int p = 0; p < 2; p++) begin
      for (int n = 0; n < 4; n++) begin
        wr(AICS_OFS_CH123, 16'(n * 2 + p));
        chk(r123_l, exp123(p[0], n[1:0], 1'b1));
        if (n != 3) chk(r123_s, exp123(p[0], n[1:0], 1'b0));
        else chk(sel_s, 1'b1);
      end
    end
    wr(AICS_OFS_CH123, 16'h0000);
    for (int c = 0; c < 10; c++) begin
      wr(AICS_OFS_CH0, {8'h00, c[0], 2'b00, c[4:0]});
      chk({sl[0], sel_l}, {c[3:0], 1'b0});
      chk(sl[1], c[0] ? 4'h1 : AICS_SRC_VREF_N);
      if (c == 4 || c == 5) chk({ss[0], sel_s}, {AICS_SRC_NC, 1'b1});
      if (c < 4 || c == 6 || c == 7) chk({ss[0], sel_s}, {c[3:0], 1'b0});
    end
    wr(AICS_OFS_SCAN, 16'h0211);
    wr(AICS_OFS_CTRL, 16'h0002);
    chk(sl[0], 4'h0);
    for (int i = 0; i < 3; i++) begin
      pulse(i[0]);
      chk(sl[0], scan_l[i]);
      chk(ss[0], scan_s[i]);
    end
    wr(AICS_OFS_CTRL, 16'h0000);
    wr(AICS_OFS_CH123, 16'h0500);
    wr(AICS_OFS_CH0, 16'h8502);
    pulse(1'b0);
    chk({r123_l, sl[0]}, {exp123(1'b0, 2'h0, 1'b1), 4'h2});
    wr(AICS_OFS_CTRL, 16'h0001);
    for (int i = 0; i < 3; i++) begin
      if (i == 1) chk({r123_l, sl[0], sl[1]}, {exp123(1'b1, 2'h2, 1'b1), 8'h51});
      else chk({r123_l, sl[0], sl[1]}, {exp123(1'b0, 2'h0, 1'b1), 4'h2, AICS_SRC_VREF_N});
      pulse(1'b1);
    end
    wr(AICS_OFS_CTRL, 16'h0004);
    chk(r123_l, {6{AICS_SRC_NC}});
    wr(AICS_OFS_CTRL, 16'h0000);
    wr(AICS_OFS_CH0, 16'h0003);
    wr(AICS_OFS_PORT, 16'h0008);
    chk({sl[0], pdm_l}, {AICS_SRC_AGND, 10'h008});
    wr(AICS_OFS_PORT, 16'h0000);
    chk({sl[0], pdm_l}, {4'h3, 10'h000});
    wr(AICS_OFS_CTRL, 16'h0008);
    wr(AICS_OFS_PORT, 16'h0008);
    chk({sl[0], pdm_l}, {4'h3, 10'h3FF});
    conclude();
  end
endmodule
